// File: dbs_async_fifo.sv
/*
  Dual clock FIFO with gray coded pointers and two-flop pointer crossings.
  Assumes DEPTH is a power of two, at least 4; each side has its own reset.
*/
`timescale 1ns/1ps
`default_nettype none

module dbs_async_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // fill side
  input wire logic wclk,
  input wire logic wrst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  input wire logic rclk,
  input wire logic rrst_n,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW:0] wbin_r, wbin_nxt, wgray_r, wgray_nxt;
  logic [AW:0] rbin_r, rbin_nxt, rgray_r, rgray_nxt;
  logic [AW:0] rgray_s1_r, rgray_s2_r, wgray_s1_r, wgray_s2_r;

  function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  assign in_ready = (wgray_r != {~rgray_s2_r[AW:AW-1], rgray_s2_r[AW-2:0]});
  assign out_valid = (rgray_r != wgray_s2_r);
  assign out_data = mem[rbin_r[AW-1:0]];

  always_comb begin
    wbin_nxt = (in_valid && in_ready) ? wbin_r + 1'b1 : wbin_r;
    wgray_nxt = bin2gray(wbin_nxt);
    rbin_nxt = (out_valid && out_ready) ? rbin_r + 1'b1 : rbin_r;
    rgray_nxt = bin2gray(rbin_nxt);
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge wclk) begin
    if (in_valid && in_ready) begin
      mem[wbin_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge wclk or negedge wrst_n) begin
    if (!wrst_n) begin
      wbin_r <= '0;
      wgray_r <= '0;
      rgray_s1_r <= '0;
      rgray_s2_r <= '0;
    end else begin
      wbin_r <= wbin_nxt;
      wgray_r <= wgray_nxt;
      rgray_s1_r <= rgray_r;
      rgray_s2_r <= rgray_s1_r;
    end
  end

  always_ff @(posedge rclk or negedge rrst_n) begin
    if (!rrst_n) begin
      rbin_r <= '0;
      rgray_r <= '0;
      wgray_s1_r <= '0;
      wgray_s2_r <= '0;
    end else begin
      rbin_r <= rbin_nxt;
      rgray_r <= rgray_nxt;
      wgray_s1_r <= wgray_r;
      wgray_s2_r <= wgray_s1_r;
    end
  end

endmodule // dbs_async_fifo

`default_nettype wire

// File: dbs_burst_array.sv
/*
  Storage array with one write pair and one read pair per cycle, lane
  masked writes and write-through forwarding to a same-cycle read.
  Assumes pair indices are even and clk is the input timing clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dbs_params.svh"

module dbs_burst_array
  import dbs_pkg::*;
#(
  parameter int DATA_W = `DBS_DATA_W,
  parameter int ADDR_W = `DBS_ADDR_W,
  parameter int LANE_W = `DBS_LANE_W
) (
  // clock
  input wire logic clk,
  // pair port
  dbs_commit_if.mem port
);
  localparam int LANES = DATA_W / LANE_W;
  localparam int WORDS = 2 ** (ADDR_W + 2);

  logic [DATA_W-1:0] mem [0:WORDS-1];
  logic [ADDR_W+1:0] wr_odd_idx;
  logic [ADDR_W+1:0] rd_odd_idx;

  // selected lanes take new data, others keep the old word
  function automatic logic [DATA_W-1:0] lane_merge(
    input logic [DATA_W-1:0] old_w,
    input logic [DATA_W-1:0] new_w,
    input logic [LANES-1:0] sel_n
  );
    logic [DATA_W-1:0] res;
    res = old_w;
    for (int i = 0; i < LANES; i++) begin
      if (!sel_n[i]) begin
        res[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
      end
    end
    return res;
  endfunction

  assign wr_odd_idx = {port.idx[ADDR_W+1:1], 1'b1};
  assign rd_odd_idx = {port.rd_idx[ADDR_W+1:1], 1'b1};

  ////////////////////////////////////////////////////////////////////////
  // each beat carries its own lane selects
  always_ff @(posedge clk) begin
    if (port.valid) begin
      mem[port.idx] <= lane_merge(mem[port.idx], port.even, port.even_sel_n);
      mem[wr_odd_idx] <= lane_merge(mem[wr_odd_idx], port.odd, port.odd_sel_n);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pair being written this cycle is forwarded to the reader
  always_comb begin
    port.rd_even = mem[port.rd_idx];
    port.rd_odd = mem[rd_odd_idx];
    if (port.valid && (port.idx == port.rd_idx)) begin
      port.rd_even = lane_merge(mem[port.rd_idx], port.even, port.even_sel_n);
      port.rd_odd = lane_merge(mem[rd_odd_idx], port.odd, port.odd_sel_n);
    end
  end

endmodule // dbs_burst_array

`default_nettype wire

// File: dbs_commit_if.sv
/*
  Carrier between the port logic and the storage array: one committed
  write pair and one read pair lookup per cycle.
  Assumes the array end runs on the positive input timing clock; odd and odd_sel_n come from negative edge flops.
*/
`timescale 1ns/1ps
`default_nettype none

interface dbs_commit_if #(
  parameter int DATA_W = 18,
  parameter int ADDR_W = 19,
  parameter int LANES = 2
);
  logic valid;
  logic [ADDR_W+1:0] idx;
  logic [DATA_W-1:0] even;
  logic [DATA_W-1:0] odd;
  logic [LANES-1:0] even_sel_n;
  logic [LANES-1:0] odd_sel_n;
  logic [ADDR_W+1:0] rd_idx;
  logic [DATA_W-1:0] rd_even;
  logic [DATA_W-1:0] rd_odd;

  modport src (output valid, idx, even, odd, even_sel_n, odd_sel_n, rd_idx,
               input rd_even, rd_odd);
  modport mem (input valid, idx, even, odd, even_sel_n, odd_sel_n, rd_idx,
               output rd_even, rd_odd);
endinterface

`default_nettype wire

// File: dbs_master_model.sv
/*
  Bus master model of the burst SRAM port: makes the link clock pair,
  presents one request per positive edge and the write beats, logs read
  beats 7 ns after each link edge.
  Assumes requests come through req and beats through bd and bl.
*/
`timescale 1ns/1ps
`default_nettype none

module dbs_master_model #(
  parameter int AW = 6,
  parameter int DW = 18
) (
  // link clocks
  output logic in_timing_pos,
  output logic in_timing_neg,
  output logic out_timing_pos,
  output logic out_timing_neg,
  // requests and write beats
  output logic read_port_sel_n,
  output logic write_port_sel_n,
  output logic [AW-1:0] addr,
  output logic [DW-1:0] wdata,
  output logic [1:0] lane_write_sel_n,
  // read beats
  input wire logic [DW-1:0] rdata,
  input wire logic rdata_oe_n
);
  logic run = 1'b1;
  logic single = 1'b0;
  logic pv = 1'b0;
  logic pr = 1'b1;
  logic pw = 1'b1;
  logic [AW-1:0] pa = '0;
  int hc = 0;
  int last_t = 0;
  logic [DW-1:0] bd [4];
  logic [1:0] bl [4];
  logic [DW-1:0] sd [64];
  logic [1:0] sl [64];
  logic sv [64] = '{default: 1'b0};
  logic [DW-1:0] rq [64];
  logic ro [64];

  ////////////////////////////////////////////////////////////////////
  // output clocks parked high when stopped or strapped
  assign out_timing_pos = (single || !run) ? 1'b1 : in_timing_pos;
  assign out_timing_neg = (single || !run) ? 1'b1 : in_timing_neg;

  initial begin
    in_timing_pos = 1'b0;
    in_timing_neg = 1'b1;
    read_port_sel_n = 1'b1;
    write_port_sel_n = 1'b1;
    addr = '0;
    wdata = '0;
    lane_write_sel_n = 2'h3;
    #4;
    forever begin
      #15;
      if (run || in_timing_pos) in_timing_pos = ~in_timing_pos;
      in_timing_neg = ~in_timing_pos;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // each edge drives what the next edge samples
  always @(posedge in_timing_pos or posedge in_timing_neg) begin
    hc = hc + 1;
    if (sv[(hc + 1) % 64]) begin
      wdata <= sd[(hc + 1) % 64];
      lane_write_sel_n <= sl[(hc + 1) % 64];
      sv[(hc + 1) % 64] = 1'b0;
    end else begin
      // released lines never keep the last value
      wdata <= ~wdata;
      lane_write_sel_n <= ~lane_write_sel_n;
    end
    if (in_timing_pos) begin
      read_port_sel_n <= pr;
      write_port_sel_n <= pw;
      addr <= pv ? pa : ~addr;
      for (int i = 0; i < 4; i++) begin
        if (pv && !pw) begin
          sd[(hc + 4 + i) % 64] = bd[i];
          sl[(hc + 4 + i) % 64] = bl[i];
          sv[(hc + 4 + i) % 64] = 1'b1;
        end
      end
      if (pv) last_t = hc + 2;
      pv = 1'b0;
      pr = 1'b1;
      pw = 1'b1;
    end
    #7;
    rq[hc % 64] = rdata;
    ro[hc % 64] = rdata_oe_n;
  end

  // t returns the log index of the edge that samples the request
  task automatic req(input logic r, input logic w, input logic [AW-1:0] a, output int t);
    pv = 1'b1;
    pr = r;
    pw = w;
    pa = a;
    @(negedge in_timing_pos);
    t = last_t;
  endtask
endmodule // dbs_master_model

`default_nettype wire

// File: dbs_params.svh
/*
  Constants of the burst SRAM port: widths, burst shape, FIFO depth and
  synchroniser length. Included by the design files by bare name.
*/
`ifndef DBS_PARAMS_SVH
`define DBS_PARAMS_SVH

`define DBS_DATA_W 18
`define DBS_ADDR_W 19
`define DBS_LANE_W 9
`define DBS_BURST_LEN 4
`define DBS_FIFO_DEPTH 8
`define DBS_RD_PAIRS 2'h2
`define DBS_WR_FIRST 2'h1
`define DBS_WR_SECOND 2'h2
`define DBS_STRAP_FILL 2'h3

`endif

// File: dbs_pkg.sv
/*
  Types of the burst SRAM port.
  Assumes nothing of its surroundings.
*/
package dbs_pkg;

  // operation started at the last input timing edge
  typedef enum logic [1:0] {OP_IDLE, OP_READ, OP_WRITE} dbs_op_e;

endpackage

// File: dbs_sram_port.sv
/*
  Port logic of a separate-I/O burst-of-four DDR SRAM: request arbitration,
  write beat capture on both input timing clocks, read beat delivery,
  output enable control, power-on strap, and a commit monitor stream
  crossed into the mclk domain through a FIFO.
  Assumes in_timing_neg is the complement of in_timing_pos and that read
  data is timed by the input clock pair (zero skew to the output clocks).
*/
// Contract
// - write: select at t, data t+1..t+2
// - read beats from neg t+1 to pos t+3
// - beats address A, A+1, A+2, A+3
// - data captured on both input clock rises
// - same-type request next edge ignored
// - after read, write may start next edge
// - reset: ports deselected, outputs high impedance
// - narrow width: two nine-bit lanes gated
// - wide width: four nine-bit lanes gated
// - each beat uses its own lane selects
// - both selected: alternate, read first
// - deselected read: off after next pos edge
// - read after write forwards new data
`timescale 1ns/1ps
`default_nettype none
`include "dbs_params.svh"

module dbs_sram_port
  import dbs_pkg::*;
#(
  parameter int DATA_W = `DBS_DATA_W,
  parameter int ADDR_W = `DBS_ADDR_W,
  parameter int FIFO_DEPTH = `DBS_FIFO_DEPTH,
  parameter int LANES = DATA_W / `DBS_LANE_W,
  parameter int MON_W = ADDR_W + 2 + 2 * DATA_W + 2 * LANES
) (
  // system clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // input timing clock pair
  input wire logic in_timing_pos,
  input wire logic in_timing_neg,
  // output timing clock pair, strap only
  input wire logic out_timing_pos,
  input wire logic out_timing_neg,
  // address and port selects
  input wire logic read_port_sel_n,
  input wire logic write_port_sel_n,
  input wire logic [ADDR_W-1:0] addr,
  // write data
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [LANES-1:0] lane_write_sel_n,
  // read data
  output logic [DATA_W-1:0] rdata,
  output logic rdata_oe_n,
  // mode
  output logic single_clk_mode,
  // commit monitor, mclk domain except mon_space (in_timing_pos domain)
  output logic mon_valid,
  input wire logic mon_ready,
  output logic [MON_W-1:0] mon_data,
  output logic mon_space
);

  ////////////////////////////////////////////////////////////////////////
  // link reset: asynchronous assert, release on the link clock
  logic link_rst_s1_r, link_rst_n;

  always_ff @(posedge in_timing_pos or negedge reset_n) begin
    if (!reset_n) begin
      link_rst_s1_r <= 1'b0;
      link_rst_n <= 1'b0;
    end else begin
      link_rst_s1_r <= 1'b1;
      link_rst_n <= link_rst_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // request arbitration
  dbs_op_e prev_op_r, prev_op_nxt;
  logic rd_req, wr_req, grant_rd, grant_wr;

  always_comb begin
    rd_req = !read_port_sel_n && (prev_op_r != OP_READ);
    wr_req = !write_port_sel_n && (prev_op_r != OP_WRITE);
    grant_rd = rd_req && !(wr_req && (prev_op_r == OP_READ));
    grant_wr = wr_req && !grant_rd;
    prev_op_nxt = grant_rd ? OP_READ : (grant_wr ? OP_WRITE : OP_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////
  // read and write burst state, positive phase
  logic [ADDR_W-1:0] rd_addr_r, rd_addr_nxt, wr_addr_r, wr_addr_nxt;
  logic [1:0] rd_left_r, rd_left_nxt, wr_stage_r, wr_stage_nxt;
  logic pair_valid_r, pair_valid_nxt;
  logic [DATA_W-1:0] pair_even_r, pair_even_nxt, pair_odd_r, pair_odd_nxt;
  logic commit_r, commit_nxt, commit_pair_r, commit_pair_nxt;
  logic [ADDR_W-1:0] commit_addr_r, commit_addr_nxt;
  logic [DATA_W-1:0] hold_r, hold_nxt;
  logic [LANES-1:0] hold_sel_r, hold_sel_nxt;
  logic [DATA_W-1:0] q_pos_r, q_pos_nxt;
  logic drv_pos_r, drv_pos_nxt;

  dbs_commit_if #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .LANES(LANES)) cif ();

  always_comb begin
    rd_addr_nxt = rd_addr_r;
    rd_left_nxt = (rd_left_r != 2'h0) ? rd_left_r - 2'h1 : 2'h0;
    pair_valid_nxt = (rd_left_r != 2'h0);
    pair_even_nxt = pair_even_r;
    pair_odd_nxt = pair_odd_r;
    if (rd_left_r != 2'h0) begin
      pair_even_nxt = cif.rd_even;
      pair_odd_nxt = cif.rd_odd;
    end
    if (grant_rd) begin
      rd_addr_nxt = addr;
      rd_left_nxt = `DBS_RD_PAIRS;
    end
    wr_addr_nxt = wr_addr_r;
    wr_stage_nxt = (wr_stage_r == `DBS_WR_FIRST) ? `DBS_WR_SECOND : 2'h0;
    commit_nxt = (wr_stage_r != 2'h0);
    commit_pair_nxt = (wr_stage_r == `DBS_WR_SECOND);
    commit_addr_nxt = commit_addr_r;
    hold_nxt = hold_r;
    hold_sel_nxt = hold_sel_r;
    if (wr_stage_r != 2'h0) begin
      hold_nxt = wdata;
      hold_sel_nxt = lane_write_sel_n;
      commit_addr_nxt = wr_addr_r;
    end
    if (grant_wr) begin
      wr_addr_nxt = addr;
      wr_stage_nxt = `DBS_WR_FIRST;
    end
    // odd beat of each pair goes out on the positive edge
    q_pos_nxt = pair_valid_r ? pair_odd_r : q_pos_r;
    drv_pos_nxt = pair_valid_r;
  end

  always_ff @(posedge in_timing_pos or negedge link_rst_n) begin
    if (!link_rst_n) begin
      prev_op_r <= OP_IDLE;
      rd_addr_r <= '0;
      rd_left_r <= 2'h0;
      wr_addr_r <= '0;
      wr_stage_r <= 2'h0;
      pair_valid_r <= 1'b0;
      pair_even_r <= '0;
      pair_odd_r <= '0;
      commit_r <= 1'b0;
      commit_pair_r <= 1'b0;
      commit_addr_r <= '0;
      hold_r <= '0;
      hold_sel_r <= '1;
      q_pos_r <= '0;
      drv_pos_r <= 1'b0;
    end else begin
      prev_op_r <= prev_op_nxt;
      rd_addr_r <= rd_addr_nxt;
      rd_left_r <= rd_left_nxt;
      wr_addr_r <= wr_addr_nxt;
      wr_stage_r <= wr_stage_nxt;
      pair_valid_r <= pair_valid_nxt;
      pair_even_r <= pair_even_nxt;
      pair_odd_r <= pair_odd_nxt;
      commit_r <= commit_nxt;
      commit_pair_r <= commit_pair_nxt;
      commit_addr_r <= commit_addr_nxt;
      hold_r <= hold_nxt;
      hold_sel_r <= hold_sel_nxt;
      q_pos_r <= q_pos_nxt;
      drv_pos_r <= drv_pos_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // negative phase: odd write beat in, even read beat out
  logic [DATA_W-1:0] d_neg_r, d_neg_nxt, q_neg_r, q_neg_nxt;
  logic [LANES-1:0] sel_neg_r, sel_neg_nxt;
  logic drv_neg_r, drv_neg_nxt;

  always_comb begin
    d_neg_nxt = commit_r ? wdata : d_neg_r;
    sel_neg_nxt = commit_r ? lane_write_sel_n : sel_neg_r;
    q_neg_nxt = pair_valid_r ? pair_even_r : q_pos_r;
    // keep driving the last beat until the next positive edge
    drv_neg_nxt = pair_valid_r || drv_pos_r;
  end

  always_ff @(posedge in_timing_neg or negedge link_rst_n) begin
    if (!link_rst_n) begin
      d_neg_r <= '0;
      sel_neg_r <= '1;
      q_neg_r <= '0;
      drv_neg_r <= 1'b0;
    end else begin
      d_neg_r <= d_neg_nxt;
      sel_neg_r <= sel_neg_nxt;
      q_neg_r <= q_neg_nxt;
      drv_neg_r <= drv_neg_nxt;
    end
  end

  // parked clocks freeze the selection as well as the flops
  assign rdata = in_timing_pos ? q_pos_r : q_neg_r;
  assign rdata_oe_n = in_timing_pos ? !drv_pos_r : !drv_neg_r;

  ////////////////////////////////////////////////////////////////////////
  // array hookup
  assign cif.valid = commit_r;
  assign cif.idx = {commit_addr_r, commit_pair_r, 1'b0};
  assign cif.even = hold_r;
  assign cif.odd = d_neg_r;
  assign cif.even_sel_n = hold_sel_r;
  assign cif.odd_sel_n = sel_neg_r;
  assign cif.rd_idx = {rd_addr_r, (rd_left_r == 2'h1), 1'b0};

  dbs_burst_array #(
    .DATA_W(DATA_W),
    .ADDR_W(ADDR_W),
    .LANE_W(`DBS_LANE_W)
  ) u_array (
    .clk(in_timing_pos),
    .port(cif)
  );

  ////////////////////////////////////////////////////////////////////////
  // single clock strap, caught after reset release
  logic strap_s1_r, strap_s2_r, strap_s3_r, strap_done_r, single_r;
  logic strap_done_nxt, single_nxt;
  logic [1:0] strap_cnt_r, strap_cnt_nxt;

  // judge the strap only once the three stages hold sampled values
  always_comb begin
    strap_cnt_nxt = (strap_cnt_r == `DBS_STRAP_FILL) ? strap_cnt_r : strap_cnt_r + 2'h1;
    strap_done_nxt = strap_done_r
      || ((strap_cnt_r == `DBS_STRAP_FILL) && (strap_s2_r == strap_s3_r));
    single_nxt = strap_done_r ? single_r : strap_s3_r;
  end

  always_ff @(posedge in_timing_pos or negedge link_rst_n) begin
    if (!link_rst_n) begin
      strap_s1_r <= 1'b0;
      strap_s2_r <= 1'b0;
      strap_s3_r <= 1'b0;
      strap_done_r <= 1'b0;
      single_r <= 1'b0;
      strap_cnt_r <= 2'h0;
    end else begin
      strap_cnt_r <= strap_cnt_nxt;
      strap_s1_r <= out_timing_pos && out_timing_neg;
      strap_s2_r <= strap_s1_r;
      strap_s3_r <= strap_s2_r;
      strap_done_r <= strap_done_nxt;
      single_r <= single_nxt;
    end
  end

  assign single_clk_mode = single_r;

  ////////////////////////////////////////////////////////////////////////
  // committed pairs toward the mclk domain
  dbs_async_fifo #(
    .WIDTH(MON_W),
    .DEPTH(FIFO_DEPTH)
  ) u_mon_fifo (
    .wclk(in_timing_pos),
    .wrst_n(link_rst_n),
    .in_valid(commit_r),
    .in_ready(mon_space),
    .in_data({cif.idx, hold_r, d_neg_r, hold_sel_r, sel_neg_r}),
    .rclk(mclk),
    .rrst_n(reset_n),
    .out_valid(mon_valid),
    .out_ready(mon_ready),
    .out_data(mon_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // checks on the link domain
  a_read_pairs: assert property (@(posedge in_timing_pos) disable iff (!link_rst_n)
    grant_rd |=> ##1 pair_valid_r ##1 pair_valid_r)
    else $error("read burst did not fetch two pairs");

  a_read_repeat: assert property (@(posedge in_timing_pos) disable iff (!link_rst_n)
    grant_rd |=> !grant_rd)
    else $error("read started on consecutive edges");

  a_write_repeat: assert property (@(posedge in_timing_pos) disable iff (!link_rst_n)
    grant_wr |=> !grant_wr)
    else $error("write started on consecutive edges");

  a_write_commit: assert property (@(posedge in_timing_pos) disable iff (!link_rst_n)
    grant_wr |=> ##1 (commit_r && !commit_pair_r) ##1 (commit_r && commit_pair_r))
    else $error("write pairs not committed at t+2 and t+3");

  a_burst_addr: assert property (@(posedge in_timing_pos) disable iff (!link_rst_n)
    (commit_r && commit_pair_r) |-> $past(commit_r) && !$past(commit_pair_r)
      && (commit_addr_r == $past(commit_addr_r)))
    else $error("second pair of burst lost its address");

  a_write_after_rd: assert property (@(posedge in_timing_pos) disable iff (!link_rst_n)
    (prev_op_r == OP_READ && !write_port_sel_n) |-> grant_wr)
    else $error("write after read not started");

  a_both_alternate: assert property (@(posedge in_timing_pos) disable iff (!link_rst_n)
    (!read_port_sel_n && !write_port_sel_n) |->
      (prev_op_r == OP_READ) ? grant_wr : grant_rd)
    else $error("both selected: wrong port won");

  a_idle_nop: assert property (@(posedge in_timing_pos) disable iff (!link_rst_n)
    (read_port_sel_n && write_port_sel_n) |=> prev_op_r == OP_IDLE)
    else $error("operation started with both ports deselected");

  a_read_tail_off: assert property (@(posedge in_timing_pos) disable iff (!link_rst_n)
    $fell(pair_valid_r) |-> drv_pos_r ##1 !drv_pos_r)
    else $error("read outputs not released after the last beat");

endmodule // dbs_sram_port

`default_nettype wire

// File: tb.sv
/*
  Testbench of the burst SRAM port: bursts, masking, arbitration,
  stopped clocks, monitor FIFO fill and drain, strap.
  Assumes the design files and dbs_master_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  import dbs_pkg::*;
  localparam int AW = 6;
  localparam int DW = 18;
  logic mclk, reset_n, mon_ready, mon_valid, mon_space, single_clk_mode, rdata_oe_n;
  logic kp, kn, cp, cn, rs_n, ws_n;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata, rdata;
  logic [1:0] lanes;
  logic [47:0] mon_data;
  logic [DW-1:0] em [256];
  int miscompares = 0;
  int n_tests = 0;

  dbs_master_model #(.AW(AW), .DW(DW)) m (
    .in_timing_pos(kp), .in_timing_neg(kn), .out_timing_pos(cp), .out_timing_neg(cn),
    .read_port_sel_n(rs_n), .write_port_sel_n(ws_n), .addr(addr), .wdata(wdata),
    .lane_write_sel_n(lanes), .rdata(rdata), .rdata_oe_n(rdata_oe_n));
  dbs_sram_port #(.ADDR_W(AW)) DUT (
    .mclk(mclk), .reset_n(reset_n), .in_timing_pos(kp), .in_timing_neg(kn),
    .out_timing_pos(cp), .out_timing_neg(cn), .read_port_sel_n(rs_n),
    .write_port_sel_n(ws_n), .addr(addr), .wdata(wdata), .lane_write_sel_n(lanes),
    .rdata(rdata), .rdata_oe_n(rdata_oe_n), .single_clk_mode(single_clk_mode),
    .mon_valid(mon_valid), .mon_ready(mon_ready), .mon_data(mon_data), .mon_space(mon_space));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  function automatic logic [DW-1:0] mrg(input logic [DW-1:0] o, input logic [DW-1:0] n,
                                        input logic [1:0] s);
    mrg = o;
    if (!s[0]) mrg[8:0] = n[8:0];
    if (!s[1]) mrg[17:9] = n[17:9];
  endfunction

  // beat b in d[b*DW +: DW], its selects in l[b*2 +: 2]
  task automatic load(input logic [AW-1:0] a, input logic [4*DW-1:0] d, input logic [7:0] l,
                      input bit upd);
    for (int b = 0; b < 4; b++) begin
      m.bd[b] = d[b*DW +: DW];
      m.bl[b] = l[b*2 +: 2];
      if (upd) em[{a, b[1:0]}] = mrg(em[{a, b[1:0]}], d[b*DW +: DW], l[b*2 +: 2]);
    end
  endtask

  task automatic idle(input int n);
    int t;
    repeat (n) m.req(1'b1, 1'b1, '0, t);
  endtask

  task automatic rdchk(input logic [AW-1:0] a, input int t);
    for (int b = 0; b < 4; b++) begin
      chk("rdata", em[{a, b[1:0]}], m.rq[(t + 3 + b) % 64]);
      chk("rdata_oe_n", 1'b0, m.ro[(t + 3 + b) % 64]);
    end
  endtask

  task automatic drain(output int n);
    n = 0;
    @(posedge mclk);
    mon_ready <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(negedge mclk);
      if (mon_valid !== 1'b1) break;
      n++;
      @(posedge mclk);
    end
    @(posedge mclk);
    mon_ready <= 1'b0;
  endtask

  task automatic do_reset(input logic sgl);
    @(posedge mclk);
    reset_n <= 1'b0;
    m.single = sgl;
    repeat (8) @(posedge mclk);
    chk("oe_reset", 1'b1, rdata_oe_n);
    chk("valid_reset", 1'b0, mon_valid);
    reset_n <= 1'b1;
    idle(8);
    chk("oe_idle", 1'b1, m.ro[(m.hc - 1) % 64]);
    chk("strap", sgl, single_clk_mode);
    $display("test reset done");
  endtask

  ////////////////////////////////////////////////////////////////////
  task automatic t_lanes();
    int t;
    load(6'h03, {18'h11114, 18'h11113, 18'h11112, 18'h11111}, 8'h00, 1'b1);
    m.req(1'b1, 1'b0, 6'h03, t);
    idle(1);
    load(6'h04, {18'h22224, 18'h22223, 18'h22222, 18'h22221}, 8'h00, 1'b1);
    m.req(1'b1, 1'b0, 6'h04, t);
    idle(1);
    load(6'h03, {18'h2EEE4, 18'h2DDD3, 18'h2CCC2, 18'h2BBB1}, 8'hE4, 1'b1);
    m.req(1'b1, 1'b0, 6'h03, t);
    idle(2);
    m.req(1'b0, 1'b1, 6'h03, t);
    idle(5);
    rdchk(6'h03, t);
    $display("test lanes done");
  endtask

  task automatic t_same();
    int t, u;
    m.req(1'b0, 1'b1, 6'h03, t);
    m.req(1'b0, 1'b1, 6'h04, u);
    idle(6);
    rdchk(6'h03, t);
    chk("oe_release", 1'b1, m.ro[(t + 8) % 64]);
    load(6'h04, {4{18'h15A5A}}, 8'h00, 1'b1);
    m.req(1'b1, 1'b0, 6'h04, t);
    load(6'h03, {4{18'h15A5A}}, 8'h00, 1'b0);
    m.req(1'b1, 1'b0, 6'h03, u);
    idle(3);
    m.req(1'b0, 1'b1, 6'h03, t);
    idle(1);
    m.req(1'b0, 1'b1, 6'h04, u);
    idle(6);
    rdchk(6'h03, t);
    rdchk(6'h04, u);
    $display("test same done");
  endtask

  task automatic t_both();
    int t, u, v;
    load(6'h06, {18'h06664, 18'h06663, 18'h06662, 18'h06661}, 8'h00, 1'b1);
    m.req(1'b1, 1'b0, 6'h06, t);
    idle(3);
    load(6'h06, {18'h3C0D4, 18'h3C0D3, 18'h3C0D2, 18'h3C0D1}, 8'h00, 1'b0);
    m.req(1'b0, 1'b0, 6'h06, t);
    m.req(1'b0, 1'b0, 6'h06, u);
    m.req(1'b0, 1'b1, 6'h06, v);
    idle(6);
    rdchk(6'h06, t);
    load(6'h06, {18'h3C0D4, 18'h3C0D3, 18'h3C0D2, 18'h3C0D1}, 8'h00, 1'b1);
    rdchk(6'h06, v);
    $display("test both done");
  endtask

  task automatic t_stop();
    int t, i;
    m.req(1'b0, 1'b1, 6'h04, t);
    for (i = 0; i < 8 && m.hc != t + 3; i++) begin
      @(posedge kn);
      #1;
    end
    if (i == 8) begin
      miscompares++;
      close_out();
    end
    m.run = 1'b0;
    repeat (20) @(posedge mclk);
    chk("rdata_stop", em[8'h10], rdata);
    chk("oe_stop", 1'b0, rdata_oe_n);
    m.run = 1'b1;
    idle(5);
    rdchk(6'h04, t);
    $display("test stop done");
  endtask

  task automatic t_mon();
    int t, n;
    drain(n);
    for (int k = 0; k < 5; k++) begin
      load(6'h08 + 6'(k), {18'h0A004, 18'h0A003, 18'h0A002, 18'h0A001}, 8'h00, 1'b1);
      m.req(1'b1, 1'b0, 6'h08 + 6'(k), t);
      idle(1);
    end
    idle(2);
    repeat (10) @(posedge mclk);
    chk("mon_space", 1'b0, mon_space);
    chk("mon_first", {6'h08, 2'h0, 18'h0A001, 18'h0A002, 4'h0}, mon_data);
    drain(n);
    chk("mon_count", 48'h8, 48'(n));
    chk("mon_empty", 1'b0, mon_valid);
    $display("test monitor done");
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    mon_ready = 1'b0;
    do_reset(1'b0);
    t_lanes();
    t_same();
    t_both();
    t_stop();
    t_mon();
    do_reset(1'b1);
    close_out();
  end

  initial begin
    #100000;
    miscompares++;
    close_out();
  end
endmodule // tb

`default_nettype wire
